//--- cpic_pkg.sv
// Behaviour
// - Increase adds value to newest record, writes sum into oldest record.
// - After increase the written record becomes newest, addressed as record 1.
// - Increase with unmet access condition answers 69 82.
// - Successful increase returns new record value followed by added value.
// - Sum beyond all-FF record leaves file unchanged, answers 98 50.
// - Increase on file whose rule lacks increase code answers error.
// - Verify compares received PIN data with stored PIN reference.
// - Verify runs only on enabled, unblocked PIN; disabled PIN gives error.
// - PIN-guarded operation needs prior good verify unless PIN disabled, else 69 82.
// - Correct PIN restores remaining attempts to 3.
// - Wrong PIN decrements remaining attempts by one.
// - Three wrong presentations block PIN; count survives card resets.
// - Empty verify answers 63 CX with attempts, counter unchanged.
// - Failed verify of unblocked PIN answers 63 CX with decremented count.
// - Any verify on blocked PIN answers 69 83, also after card reset.
// - Blocked PIN keeps dependent access conditions unfulfilled until unblock.
// - Successful verify answers 90 00.
// - Successful unblock restores remaining attempts to 3.
package cpic_pkg;
	localparam int REC_BYTES = 3;
	localparam int PIN_BYTES = 8;
	localparam int REC_W     = REC_BYTES * 8;
	localparam int PIN_W     = PIN_BYTES * 8;
	localparam int TRY_W     = 2;

	localparam logic [TRY_W-1:0] PIN_TRIES_INIT = 2'h3;
	localparam logic [PIN_W-1:0] PIN_REF_RESET  = 64'h3030_3030_3030_3030;

	localparam logic [7:0] SW1_OK      = 8'h90;
	localparam logic [7:0] SW2_OK      = 8'h00;
	localparam logic [7:0] SW1_SEC     = 8'h69;
	localparam logic [7:0] SW2_SEC_NOT = 8'h82;
	localparam logic [7:0] SW2_BLOCKED = 8'h83;
	localparam logic [7:0] SW2_COND    = 8'h85;
	localparam logic [7:0] SW2_DENIED  = 8'h86;
	localparam logic [7:0] SW1_MAX     = 8'h98;
	localparam logic [7:0] SW2_MAX     = 8'h50;
	localparam logic [7:0] SW1_RETRY   = 8'h63;
	localparam logic [3:0] SW2_RETRY_H = 4'hC;
	localparam logic [7:0] SW1_PARAM   = 8'h6A;
	localparam logic [7:0] SW2_NO_REC  = 8'h83;
	localparam logic [7:0] SW1_INS     = 8'h6D;
	localparam logic [7:0] SW2_INS     = 8'h00;

	localparam logic [3:0] RSP_LEN_NONE = 4'h0;
	localparam logic [3:0] RSP_LEN_REC  = 4'h3;
	localparam logic [3:0] RSP_LEN_INC  = 4'h6;

	typedef enum logic [2:0] {
		OP_INCREASE = 3'h0,
		OP_VERIFY   = 3'h1,
		OP_READ_REC = 3'h2,
		OP_ACCESS   = 3'h3,
		OP_UNBLOCK  = 3'h4,
		OP_DISABLE  = 3'h5,
		OP_ENABLE   = 3'h6
	} cpic_op_e;

	typedef struct packed {
		cpic_op_e         op;
		logic             pin_empty;
		logic             cond_is_pin;
		logic             inc_listed;
		logic [7:0]       rec_num;
		logic [PIN_W-1:0] pin;
		logic [REC_W-1:0] value;
	} cpic_cmd_s;

	typedef struct packed {
		logic [7:0]         sw1;
		logic [7:0]         sw2;
		logic [3:0]         len;
		logic [2*REC_W-1:0] data;
	} cpic_rsp_s;
endpackage

//--- cpic_rec_adder.sv
`timescale 1ns/10ps
`default_nettype none
module cpic_rec_adder
	import cpic_pkg::*;
#(
	parameter int W = REC_W
)
(
	input  wire logic [W-1:0] base_in,
	input  wire logic [W-1:0] addend_in,
	output logic      [W-1:0] sum_out,
	output logic              overflow_out
);
	logic [W:0] wide_sum;

	// Carry out of the top byte means the result passes all bytes FF
	assign wide_sum     = {1'b0, base_in} + {1'b0, addend_in};
	assign sum_out      = wide_sum[W-1:0];
	assign overflow_out = wide_sum[W];
endmodule
`default_nettype wire

//--- cpic_retry_ctr.sv
`timescale 1ns/10ps
`default_nettype none
module cpic_retry_ctr
	import cpic_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             good_in,
	input  wire logic             bad_in,
	input  wire logic             restore_in,
	output logic      [TRY_W-1:0] retries_out,
	output logic                  blocked_out
);
	logic [TRY_W-1:0] retries;

	// Power-on reset, a good PIN and a restore reload it to 3; card resets leave it alone
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			retries <= PIN_TRIES_INIT;
		end
		else if (good_in || restore_in)
		begin
			retries <= PIN_TRIES_INIT;
		end
		else if (bad_in && (retries != '0))
		begin
			retries <= retries - 2'h1;
		end
	end

	assign retries_out = retries;
	assign blocked_out = (retries == '0);
endmodule
`default_nettype wire

//--- cpic_cmd_engine.sv
`timescale 1ns/10ps
`default_nettype none
module cpic_cmd_engine
	import cpic_pkg::*;
#(
	parameter int               NUM_REC   = 4,
	parameter logic [PIN_W-1:0] PIN_RESET = PIN_REF_RESET
)
(
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             card_reset_in,
	input  wire logic             cmd_valid_in,
	output logic                  cmd_ready_out,
	input  wire cpic_cmd_s        cmd_in,
	output logic                  rsp_valid_out,
	input  wire logic             rsp_ready_in,
	output cpic_rsp_s             rsp_out,
	output logic      [TRY_W-1:0] pin_retries_out,
	output logic                  pin_blocked_out,
	output logic                  pin_disabled_out,
	output logic                  pin_verified_out
);
	localparam int IDX_W = (NUM_REC > 1) ? $clog2(NUM_REC) : 1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_RESP = 2'b11
	} cpic_state_e;

	cpic_state_e      state;
	cpic_state_e      next_state;
	cpic_cmd_s        cmd_q;
	cpic_rsp_s        rsp_q;
	cpic_rsp_s        next_rsp;

	logic [REC_W-1:0] rec_mem [NUM_REC];
	logic [IDX_W-1:0] newest;
	logic [PIN_W-1:0] pin_ref;
	logic             pin_disabled;
	logic             pin_verified;

	logic [TRY_W-1:0] retries;
	logic             blocked;
	logic             pin_match;
	logic             access_ok;
	logic             pin_good;
	logic             pin_bad;
	logic             pin_restore;
	logic             set_verified;
	logic             set_disabled;
	logic             clr_disabled;
	logic             load_pin;
	logic             inc_write;
	logic [IDX_W-1:0] oldest;
	logic [IDX_W-1:0] read_idx;
	logic [REC_W-1:0] inc_sum;
	logic             inc_ovf;

	// Record k counted back from the newest; record 1 is the newest itself
	function automatic logic [IDX_W-1:0] rec_index(input logic [IDX_W-1:0] top,
	                                              input int unsigned k);
		int unsigned pos;
		pos = (int'(top) + NUM_REC - ((k - 1) % NUM_REC)) % NUM_REC;
		return pos[IDX_W-1:0];
	endfunction

	function automatic cpic_rsp_s status(input logic [7:0] sw1, input logic [7:0] sw2);
		cpic_rsp_s r;
		r      = '0;
		r.sw1  = sw1;
		r.sw2  = sw2;
		r.len  = RSP_LEN_NONE;
		return r;
	endfunction

	function automatic cpic_rsp_s retry_status(input logic [TRY_W-1:0] left);
		logic [3:0] nib;
		nib = 4'(left);
		return status(SW1_RETRY, {SW2_RETRY_H, nib});
	endfunction

	cpic_retry_ctr u_retry
	(
		.clk_in      (clk_in),
		.sys_rst_in  (sys_rst_in),
		.good_in     (pin_good),
		.bad_in      (pin_bad),
		.restore_in  (pin_restore),
		.retries_out (retries),
		.blocked_out (blocked)
	);

	// Oldest record is the one just past the newest in the cycle
	assign oldest   = rec_index(newest, NUM_REC);
	assign read_idx = rec_index(newest, int'(cmd_q.rec_num));

	cpic_rec_adder #(
		.W (REC_W)
	) u_adder
	(
		.base_in      (rec_mem[newest]),
		.addend_in    (cmd_q.value),
		.sum_out      (inc_sum),
		.overflow_out (inc_ovf)
	);

	assign pin_match = (cmd_q.pin == pin_ref);
	// A blocked PIN denies access even if verified earlier in the session
	assign access_ok = !blocked && (pin_disabled || pin_verified);

	always_comb
	begin
		next_rsp     = status(SW1_INS, SW2_INS);
		pin_good     = 1'b0;
		pin_bad      = 1'b0;
		pin_restore  = 1'b0;
		set_verified = 1'b0;
		set_disabled = 1'b0;
		clr_disabled = 1'b0;
		load_pin     = 1'b0;
		inc_write    = 1'b0;
		if (state == ST_EXEC)
		begin
			case (cmd_q.op)
				OP_INCREASE:
				begin
					if (!cmd_q.inc_listed)
					begin
						next_rsp = status(SW1_SEC, SW2_DENIED);
					end
					else if (cmd_q.cond_is_pin && !access_ok)
					begin
						next_rsp = status(SW1_SEC, SW2_SEC_NOT);
					end
					else if (inc_ovf)
					begin
						next_rsp = status(SW1_MAX, SW2_MAX);
					end
					else
					begin
						inc_write     = 1'b1;
						next_rsp      = status(SW1_OK, SW2_OK);
						next_rsp.len  = RSP_LEN_INC;
						next_rsp.data = {inc_sum, cmd_q.value};
					end
				end
				OP_VERIFY:
				begin
					if (blocked)
					begin
						next_rsp = status(SW1_SEC, SW2_BLOCKED);
					end
					else if (pin_disabled)
					begin
						next_rsp = status(SW1_SEC, SW2_COND);
					end
					else if (cmd_q.pin_empty)
					begin
						next_rsp = retry_status(retries);
					end
					else if (pin_match)
					begin
						pin_good     = 1'b1;
						set_verified = 1'b1;
						next_rsp     = status(SW1_OK, SW2_OK);
					end
					else
					begin
						pin_bad  = 1'b1;
						next_rsp = retry_status(retries - 2'h1);
					end
				end
				OP_READ_REC:
				begin
					if (cmd_q.cond_is_pin && !access_ok)
					begin
						next_rsp = status(SW1_SEC, SW2_SEC_NOT);
					end
					else if ((cmd_q.rec_num == 8'h00) || (int'(cmd_q.rec_num) > NUM_REC))
					begin
						next_rsp = status(SW1_PARAM, SW2_NO_REC);
					end
					else
					begin
						next_rsp      = status(SW1_OK, SW2_OK);
						next_rsp.len  = RSP_LEN_REC;
						next_rsp.data = {rec_mem[read_idx], {REC_W{1'b0}}};
					end
				end
				OP_ACCESS:
				begin
					if (!cmd_q.cond_is_pin || access_ok)
					begin
						next_rsp = status(SW1_OK, SW2_OK);
					end
					else
					begin
						next_rsp = status(SW1_SEC, SW2_SEC_NOT);
					end
				end
				OP_UNBLOCK:
				begin
					// Unblock key is checked before the command reaches here
					pin_restore = 1'b1;
					load_pin    = !cmd_q.pin_empty;
					next_rsp    = status(SW1_OK, SW2_OK);
				end
				OP_DISABLE, OP_ENABLE:
				begin
					if (blocked)
					begin
						next_rsp = status(SW1_SEC, SW2_BLOCKED);
					end
					else if (pin_disabled == (cmd_q.op == OP_DISABLE))
					begin
						next_rsp = status(SW1_SEC, SW2_COND);
					end
					else if (pin_match)
					begin
						pin_good     = 1'b1;
						set_disabled = (cmd_q.op == OP_DISABLE);
						clr_disabled = (cmd_q.op == OP_ENABLE);
						next_rsp     = status(SW1_OK, SW2_OK);
					end
					else
					begin
						pin_bad  = 1'b1;
						next_rsp = retry_status(retries - 2'h1);
					end
				end
				default:
				begin
					next_rsp = status(SW1_INS, SW2_INS);
				end
			endcase
		end
	end

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (cmd_valid_in)
				begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC:
			begin
				next_state = ST_RESP;
			end
			ST_RESP:
			begin
				if (rsp_ready_in)
				begin
					next_state = ST_IDLE;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state <= ST_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			cmd_q <= '0;
		end
		else if ((state == ST_IDLE) && cmd_valid_in)
		begin
			cmd_q <= cmd_in;
		end
	end

	// Status is loaded on the same edge as the persistent state changes
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			rsp_q <= '0;
		end
		else if (state == ST_EXEC)
		begin
			rsp_q <= next_rsp;
		end
	end

	// Record contents persist over card resets like the rest of the file
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			newest <= '0;
			for (int i = 0; i < NUM_REC; i++)
			begin
				rec_mem[i] <= '0;
			end
		end
		else if (inc_write)
		begin
			rec_mem[oldest] <= inc_sum;
			newest          <= oldest;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			pin_ref <= PIN_RESET;
		end
		else if (load_pin)
		begin
			pin_ref <= cmd_q.pin;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			pin_disabled <= 1'b0;
		end
		else if (set_disabled)
		begin
			pin_disabled <= 1'b1;
		end
		else if (clr_disabled)
		begin
			pin_disabled <= 1'b0;
		end
	end

	// Session flag: a card reset drops it, but a grant in the same cycle wins
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			pin_verified <= 1'b0;
		end
		else if (set_verified)
		begin
			pin_verified <= 1'b1;
		end
		else if (card_reset_in || pin_bad || pin_restore)
		begin
			pin_verified <= 1'b0;
		end
	end

	assign cmd_ready_out    = (state == ST_IDLE);
	assign rsp_valid_out    = (state == ST_RESP);
	assign rsp_out          = rsp_q;
	assign pin_retries_out  = retries;
	assign pin_blocked_out  = blocked;
	assign pin_disabled_out = pin_disabled;
	assign pin_verified_out = pin_verified;
endmodule
`default_nettype wire

//--- cpic_cmd_engine_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cpic_cmd_engine_sva
	import cpic_pkg::*;
#(
	parameter int               NUM_REC   = 4,
	parameter logic [PIN_W-1:0] PIN_RESET = PIN_REF_RESET
)
(
	input wire logic             clk_in,
	input wire logic             sys_rst_in,
	input wire logic             card_reset_in,
	input wire logic             cmd_valid_in,
	input wire logic             cmd_ready_out,
	input wire cpic_cmd_s        cmd_in,
	input wire logic             rsp_valid_out,
	input wire logic             rsp_ready_in,
	input wire cpic_rsp_s        rsp_out,
	input wire logic [TRY_W-1:0] pin_retries_out,
	input wire logic             pin_blocked_out,
	input wire logic             pin_disabled_out,
	input wire logic             pin_verified_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	logic     tk;
	cpic_op_e lop;
	assign tk = cmd_valid_in && cmd_ready_out;
	// Op of the command now answered
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			lop <= OP_ACCESS;
		else if (tk)
			lop <= cmd_in.op;
	end
	chk_rsp_latency: assert property (tk |=> !cmd_ready_out && !rsp_valid_out ##1 rsp_valid_out)
		else $error("response latency wrong");
	chk_rsp_hold: assert property (rsp_valid_out && !rsp_ready_in |=> rsp_valid_out && $stable(rsp_out))
		else $error("response not held");
	chk_block_flag: assert property (pin_blocked_out == (pin_retries_out == 2'h0))
		else $error("blocked flag wrong");
	chk_verify_good: assert property ($rose(rsp_valid_out) && lop == OP_VERIFY && rsp_out.sw1 == SW1_OK
		|-> pin_retries_out == PIN_TRIES_INIT && pin_verified_out)
		else $error("good verify state wrong");
	chk_retry_code: assert property (rsp_valid_out && rsp_out.sw1 == SW1_RETRY
		|-> rsp_out.sw2 == {SW2_RETRY_H, 2'h0, pin_retries_out})
		else $error("retry status wrong");
	chk_blocked_reject: assert property (tk && cmd_in.op == OP_VERIFY && pin_blocked_out
		|-> ##2 rsp_out.sw1 == SW1_SEC && rsp_out.sw2 == SW2_BLOCKED)
		else $error("blocked verify accepted");
	chk_access_guard: assert property (tk && cmd_in.op == OP_ACCESS && cmd_in.cond_is_pin
		&& !pin_disabled_out && !pin_verified_out |-> ##2 rsp_out.sw2 == SW2_SEC_NOT)
		else $error("access granted unverified");
	chk_inc_len: assert property (rsp_valid_out && lop == OP_INCREASE && rsp_out.sw1 == SW1_OK
		|-> rsp_out.len == RSP_LEN_INC)
		else $error("increase length wrong");
	chk_retry_step: assert property (!$stable(pin_retries_out) |-> pin_retries_out == PIN_TRIES_INIT
		|| pin_retries_out == TRY_W'($past(pin_retries_out) - 1))
		else $error("retry count jump");
endmodule
bind cpic_cmd_engine cpic_cmd_engine_sva #(.NUM_REC(NUM_REC), .PIN_RESET(PIN_RESET)) i_sva (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .card_reset_in(card_reset_in),
	.cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_in(cmd_in),
	.rsp_valid_out(rsp_valid_out), .rsp_ready_in(rsp_ready_in), .rsp_out(rsp_out),
	.pin_retries_out(pin_retries_out), .pin_blocked_out(pin_blocked_out),
	.pin_disabled_out(pin_disabled_out), .pin_verified_out(pin_verified_out));
`default_nettype wire

//--- cpic_term.sv
`timescale 1ns/10ps
`default_nettype none
module cpic_term
	import cpic_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic ready_in,
	input  wire logic rvalid_in,
	input  wire cpic_rsp_s rsp_in,
	output logic      valid_out,
	output cpic_cmd_s cmd_out,
	output logic      rready_out
);
	initial
	begin
		valid_out = 1'b0;
		cmd_out = '0;
		rready_out = 1'b0;
	end
	// Whole record-wide value and key with pin or empty flag
	task automatic xfer(input cpic_cmd_s c, input int stall, output cpic_rsp_s r, output bit ok);
		int n;
		n = 0;
		@(negedge clk_in);
		cmd_out = c;
		valid_out = 1'b1;
		// Ready is looked at where settled; the next rising edge takes the command
		while (ready_in !== 1'b1 && n < 20)
		begin
			@(negedge clk_in);
			n++;
		end
		@(negedge clk_in);
		valid_out = 1'b0;
		// Idle bus shows garbage, not the last command
		cmd_out = ~c;
		while (rvalid_in !== 1'b1 && n < 40)
		begin
			@(negedge clk_in);
			n++;
		end
		repeat (stall) @(negedge clk_in);
		r = rsp_in;
		rready_out = 1'b1;
		@(negedge clk_in);
		rready_out = 1'b0;
		ok = n < 40;
	endtask
endmodule
`default_nettype wire

//--- tb_card_pin_and_increase_cmds.sv
`timescale 1ns/10ps
`default_nettype none
module tb_card_pin_and_increase_cmds;
	import cpic_pkg::*;
	logic clk_in = 0, sys_rst_in = 1, card_reset_in = 0;
	logic cmd_valid_in, cmd_ready_out, rsp_valid_out, rsp_ready_in;
	logic pin_blocked_out, pin_disabled_out, pin_verified_out;
	logic [TRY_W-1:0] pin_retries_out;
	cpic_cmd_s cmd_in;
	cpic_rsp_s rsp_out;
	int num_errors = 0, n_checks = 0, tries = 3, nw = 0;
	bit dis = 0, ver = 0;
	logic [PIN_W-1:0] pref = PIN_REF_RESET;
	logic [REC_W-1:0] rec [4] = '{default: '0};
	always #25 clk_in = ~clk_in;
	cpic_cmd_engine i_cpic_cmd_engine (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.card_reset_in(card_reset_in), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
		.cmd_in(cmd_in), .rsp_valid_out(rsp_valid_out), .rsp_ready_in(rsp_ready_in),
		.rsp_out(rsp_out), .pin_retries_out(pin_retries_out), .pin_blocked_out(pin_blocked_out),
		.pin_disabled_out(pin_disabled_out), .pin_verified_out(pin_verified_out));
	cpic_term i_cpic_term (.clk_in(clk_in), .ready_in(cmd_ready_out), .rvalid_in(rsp_valid_out),
		.rsp_in(rsp_out), .valid_out(cmd_valid_in), .cmd_out(cmd_in), .rready_out(rsp_ready_in));
	task automatic finish_test();
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(string nm, logic [67:0] e, logic [67:0] g);
		n_checks++;
		if (e !== g)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	function automatic cpic_rsp_s model(cpic_cmd_s c);
		cpic_rsp_s e;
		logic [REC_W:0] s;
		bit blk, acc;
		e = '0;
		{e.sw1, e.sw2} = {SW1_OK, SW2_OK};
		blk = tries == 0;
		acc = !c.cond_is_pin || (!blk && (dis || ver));
		s = rec[nw] + c.value;
		case (c.op)
			OP_VERIFY:
				if (blk) {e.sw1, e.sw2} = {SW1_SEC, SW2_BLOCKED};
				else if (dis) {e.sw1, e.sw2} = {SW1_SEC, SW2_COND};
				else if (c.pin_empty) e.sw1 = SW1_RETRY;
				else if (c.pin == pref) {tries, ver} = {32'd3, 1'b1};
				else {tries, ver, e.sw1} = {tries - 1, 1'b0, SW1_RETRY};
			OP_INCREASE:
				if (!c.inc_listed) {e.sw1, e.sw2} = {SW1_SEC, SW2_DENIED};
				else if (!acc) {e.sw1, e.sw2} = {SW1_SEC, SW2_SEC_NOT};
				else if (s[REC_W]) {e.sw1, e.sw2} = {SW1_MAX, SW2_MAX};
				else
				begin
					nw = (nw + 1) % 4;
					rec[nw] = s[REC_W-1:0];
					{e.len, e.data} = {RSP_LEN_INC, s[REC_W-1:0], c.value};
				end
			OP_READ_REC:
				if (c.rec_num == 0 || c.rec_num > 4) {e.sw1, e.sw2} = {SW1_PARAM, SW2_NO_REC};
				else {e.len, e.data} = {RSP_LEN_REC, rec[(nw + 5 - c.rec_num) % 4], 24'h0};
			OP_ACCESS: if (!acc) {e.sw1, e.sw2} = {SW1_SEC, SW2_SEC_NOT};
			OP_UNBLOCK:
			begin
				{tries, ver} = {32'd3, 1'b0};
				if (!c.pin_empty) pref = c.pin;
			end
			OP_DISABLE, OP_ENABLE:
				if (blk) {e.sw1, e.sw2} = {SW1_SEC, SW2_BLOCKED};
				else if (dis == (c.op == OP_DISABLE)) {e.sw1, e.sw2} = {SW1_SEC, SW2_COND};
				else {tries, dis} = {32'd3, c.op == OP_DISABLE};
			default: {e.sw1, e.sw2} = {SW1_INS, SW2_INS};
		endcase
		if (e.sw1 == SW1_RETRY) e.sw2 = {SW2_RETRY_H, 2'h0, 2'(tries)};
		return e;
	endfunction
	task automatic go(cpic_op_e op, bit pe, bit good, logic [REC_W-1:0] v, logic [7:0] k,
		bit cp = 1, bit il = 1);
		cpic_cmd_s c;
		cpic_rsp_s e, r;
		bit ok;
		c = {op, pe, cp, il, k, good ? pref : ~pref, v};
		e = model(c);
		i_cpic_term.xfer(c, $urandom % 3, r, ok);
		if (!ok)
		begin
			num_errors++;
			finish_test();
		end
		cmp("rsp", e, r);
		cmp("state", {tries == 0, 2'(tries), dis, ver}, {pin_blocked_out, pin_retries_out,
			pin_disabled_out, pin_verified_out});
	endtask
	task automatic card_rst();
		@(negedge clk_in) card_reset_in = 1;
		@(negedge clk_in) card_reset_in = 0;
		ver = 0;
	endtask
	initial
	begin
		cpic_op_e op;
		void'($urandom(81169));
		repeat (6) @(negedge clk_in);
		sys_rst_in = 0;
		go(OP_INCREASE, 0, 1, 24'h000002, 1);
		go(OP_VERIFY, 0, 1, 0, 1);
		go(OP_INCREASE, 0, 1, 24'h000003, 1);
		go(OP_INCREASE, 0, 1, 24'h010200, 1);
		for (int k = 0; k < 6; k++) go(OP_READ_REC, 0, 1, 0, 8'(k), 0);
		go(OP_INCREASE, 0, 1, 24'hFF0000, 1);
		go(OP_INCREASE, 0, 1, 24'h00FFFD, 1);
		go(OP_INCREASE, 0, 1, 24'h010200, 1, 1, 0);
		go(OP_VERIFY, 0, 0, 0, 1);
		go(OP_VERIFY, 1, 0, 0, 1);
		go(OP_VERIFY, 0, 0, 0, 1);
		card_rst();
		go(OP_VERIFY, 0, 0, 0, 1);
		card_rst();
		go(OP_VERIFY, 0, 1, 0, 1);
		go(OP_ACCESS, 0, 1, 0, 1);
		go(OP_UNBLOCK, 1, 1, 0, 1);
		go(OP_VERIFY, 1, 1, 0, 1);
		go(OP_DISABLE, 0, 1, 0, 1);
		card_rst();
		go(OP_ACCESS, 0, 1, 0, 1);
		go(OP_VERIFY, 0, 1, 0, 1);
		go(OP_ENABLE, 0, 1, 0, 1);
		// Enable and disable only with the right pin: mismatch effects are unset
		repeat (300)
		begin
			op = cpic_op_e'(3'($urandom % 8));
			if ($urandom % 8 == 0) card_rst();
			if (op == OP_DISABLE || op == OP_ENABLE) go(op, 0, 1, 24'($urandom), 1);
			else go(op, $urandom % 4 == 0, 1'($urandom),
				$urandom % 2 ? 24'($urandom) : 24'($urandom % 512), 8'($urandom % 6),
				op != OP_READ_REC && $urandom % 2 == 1, $urandom % 8 != 0);
		end
		finish_test();
	end
endmodule
`default_nettype wire
